// ---- pkg/hpse_pkg.sv ----
// Constants, register indices and types shared by the host port ends
package hpse_pkg;
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 16;
  localparam int REG_SEL_BIT = 7;
  localparam int REG_IDX_W   = 7;
  localparam int BYTE_W      = 8;

  localparam int BUF_COUNT   = 32;
  localparam int BUF_BASIC   = 4;
  localparam int BUF_SEL_W   = 5;
  localparam int BUF_BASIC_W = 2;
  localparam int BUF_WORDS   = 16;
  localparam int PTR_W       = 4;
  localparam int MEM_AW      = BUF_SEL_W + PTR_W;
  localparam int MEM_DEPTH   = BUF_COUNT * BUF_WORDS;

  localparam int WAVE_BYTES      = 8192;
  localparam int WAVE_WORD_BYTES = 4;
  localparam int WAVE_DEPTH      = WAVE_BYTES / WAVE_WORD_BYTES;
  localparam int WAVE_AW         = 11;
  localparam int STATE_COUNT     = 256;
  localparam int STATE_W         = 8;
  localparam int CTL_PINS        = 16;
  localparam int CTL_SEL_W       = 4;

  // Waveform entry: word 0 steers transitions, word 1 drives the pins
  localparam int ENT_NEXT_T_LSB = 0;
  localparam int ENT_NEXT_F_LSB = 8;
  localparam int ENT_COND_LSB   = 16;
  localparam int ENT_POL_BIT    = 20;
  localparam int ENT_INT_BIT    = 21;
  localparam int ENT_DIR_LSB    = 16;
  localparam logic [2:0] ENT_CTL_WORD = 3'h0;
  localparam logic [2:0] ENT_PIN_WORD = 3'h1;
  localparam logic [STATE_W-1:0] STATE_RESET = 8'h00;

  localparam logic [REG_IDX_W-1:0] REG_CTRL       = 7'h00;
  localparam logic [REG_IDX_W-1:0] REG_XFER_START = 7'h01;
  localparam logic [REG_IDX_W-1:0] REG_XFER_SIZE  = 7'h02;
  localparam logic [REG_IDX_W-1:0] REG_XFER_COUNT = 7'h03;
  localparam logic [REG_IDX_W-1:0] REG_BUF_SEL    = 7'h04;
  localparam logic [REG_IDX_W-1:0] REG_WAVE_ADDR  = 7'h05;
  localparam logic [REG_IDX_W-1:0] REG_WAVE_LO    = 7'h06;
  localparam logic [REG_IDX_W-1:0] REG_WAVE_HI    = 7'h07;
  localparam logic [REG_IDX_W-1:0] REG_ENG_STATE  = 7'h08;

  localparam int CTRL_RUN_BIT    = 0;
  localparam int CTRL_MASTER_BIT = 1;
  localparam int CTRL_BUS16_BIT  = 2;
  localparam int CTRL_ALLBUF_BIT = 3;
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0004;
  localparam logic [DATA_W-1:0] ZERO_WORD  = 16'h0000;

  // Least access cycle, in tenths of a nanosecond, rounded up to cycles
  localparam int MIN_ACCESS_NS_X10 = 325;
  localparam int CLK_PERIOD_NS_X10 = 100;
  localparam int MIN_ACCESS_CYC =
    (MIN_ACCESS_NS_X10 + CLK_PERIOD_NS_X10 - 1) / CLK_PERIOD_NS_X10;
  localparam int STROBE_CNT_W = 3;

  typedef enum logic [1:0] {
    HPSE_IDLE    = 2'b00,
    HPSE_STROBE  = 2'b01,
    HPSE_RECOVER = 2'b10
  } hpse_host_state_type;
endpackage

// ---- pkg/hpse_if.sv ----
// SRAM-style pins between the external host and the device port
`timescale 1ns/1ps
interface hpse_if;
  import hpse_pkg::*;
  logic              ce_n;       // Chip enable, host driven
  logic              oe_n;       // Output enable, host driven
  logic              we_n;       // Write enable, host driven
  logic [ADDR_W-1:0] addr;       // Address, host driven
  logic [DATA_W-1:0] d_host;     // Host data out
  logic              d_host_oe_n; // Host drives data when low
  logic [DATA_W-1:0] d_dev;      // Device data out
  logic              d_dev_oe_n; // Device drives data when low
  logic              int_n;      // Interrupt to host, active low
  logic [DATA_W-1:0] d;          // Resolved data bus level

  assign d = !d_dev_oe_n ? d_dev : (!d_host_oe_n ? d_host : ZERO_WORD);

  modport device (input ce_n, oe_n, we_n, addr, d,
                  output d_dev, d_dev_oe_n, int_n);
  modport host (input d, int_n,
                output ce_n, oe_n, we_n, addr, d_host, d_host_oe_n);
endinterface

// ---- rtl/hpse_wave_engine.sv ----
// Programmable port engine: waveform memory and state stepping
`timescale 1ns/1ps
module hpse_wave_engine
  import hpse_pkg::*;
(
  input  wire logic                 core_clk, // System clock
  input  wire logic                 rst,      // Async reset, high
  input  wire logic                 step,     // Advance one state
  input  wire logic                 wr_en,    // Waveform word write
  input  wire logic [WAVE_AW-1:0]   wr_addr,  // Waveform word index
  input  wire logic [31:0]          wr_data,  // Waveform word
  input  wire logic [CTL_PINS-1:0]  ctl_in,   // Control pin levels
  output logic      [CTL_PINS-1:0]  ctl_out,  // Control pin drive
  output logic      [CTL_PINS-1:0]  ctl_oe_n, // Low where pin drives
  output logic                      int_n,    // Host interrupt, low
  output logic      [STATE_W-1:0]   state     // Current state
);
  // Eight words of 32 bits per state fill the memory exactly
  logic [31:0] wave_mem [0:WAVE_DEPTH-1];

  wire [31:0]          entry_ctl = wave_mem[{state, ENT_CTL_WORD}];
  wire [31:0]          entry_pin = wave_mem[{state, ENT_PIN_WORD}];
  wire [CTL_SEL_W-1:0] cond_sel  = entry_ctl[ENT_COND_LSB +: CTL_SEL_W];
  wire                 cond      = ctl_in[cond_sel]
                                   ^ entry_ctl[ENT_POL_BIT];
  wire [STATE_W-1:0]   next_state =
    cond ? entry_ctl[ENT_NEXT_T_LSB +: STATE_W]
         : entry_ctl[ENT_NEXT_F_LSB +: STATE_W];

  // Storage carries no reset; software loads it before setting run
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      wave_mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state    <= STATE_RESET;
      ctl_out  <= ZERO_WORD;
      ctl_oe_n <= ~ZERO_WORD;
      int_n    <= 1'b1;
    end else if (step) begin
      state    <= next_state;
      ctl_out  <= entry_pin[CTL_PINS-1:0];
      ctl_oe_n <= ~entry_pin[ENT_DIR_LSB +: CTL_PINS];
      int_n    <= entry_ctl[ENT_INT_BIT];
    end
  end
endmodule // hpse_wave_engine

// ---- rtl/hpse_device.sv ----
// Device end of the host port: SRAM-style slave, buffers, engine
`timescale 1ns/1ps
module hpse_device
  import hpse_pkg::*;
(
  input  wire logic                core_clk, // System clock, 100 MHz
  input  wire logic                rst,      // Async reset, high
  hpse_if.device                   port,     // SRAM-style host pins
  input  wire logic [CTL_PINS-1:0] ctl_in,   // Control pin levels
  output logic      [CTL_PINS-1:0] ctl_out,  // Control pin drive
  output logic      [CTL_PINS-1:0] ctl_oe_n, // Low where pin drives
  output logic      [STATE_W-1:0]  eng_state // Engine state
);
  logic                  ce_n_q;
  logic                  oe_n_q;
  logic                  we_n_q;
  logic [ADDR_W-1:0]     addr_q;
  logic [DATA_W-1:0]     din_q;
  logic [DATA_W-1:0]     ctrl;
  logic [DATA_W-1:0]     xfer_start;
  logic [DATA_W-1:0]     xfer_size;
  logic [DATA_W-1:0]     xfer_count;
  logic [BUF_SEL_W-1:0]  buf_sel;
  logic [WAVE_AW-1:0]    wave_addr;
  logic [DATA_W-1:0]     wave_lo;
  logic                  eng_int_n;
  logic [DATA_W-1:0]     buf_mem [0:MEM_DEPTH-1];

  // Pins are taken as synchronous; one stage keeps the previous level
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      addr_q <= 8'h00;
      din_q  <= ZERO_WORD;
    end else begin
      ce_n_q <= port.ce_n;
      oe_n_q <= port.oe_n;
      we_n_q <= port.we_n;
      addr_q <= port.addr;
      din_q  <= port.d;
    end
  end

  wire bus16   = ctrl[CTRL_BUS16_BIT];
  wire all_buf = ctrl[CTRL_ALLBUF_BIT];
  wire sel_reg_now = port.addr[REG_SEL_BIT];
  wire sel_reg_q   = addr_q[REG_SEL_BIT];
  wire [REG_IDX_W-1:0] rd_idx = port.addr[REG_IDX_W-1:0];
  wire [REG_IDX_W-1:0] wr_idx = addr_q[REG_IDX_W-1:0];

  // Writes commit on the closing edge of the write strobe
  wire we_rise = !we_n_q && port.we_n && !ce_n_q;
  wire wr_reg  = we_rise && sel_reg_q;
  wire wr_buf  = we_rise && !sel_reg_q;
  wire oe_rise = !oe_n_q && port.oe_n && !ce_n_q
                 && !sel_reg_q;
  // Address bit 0 only advances with the read strobe low in both
  // samples, so a plain address change between accesses never counts
  wire a0_toggle = !ce_n_q && !oe_n_q && !port.ce_n && !port.oe_n
                   && !sel_reg_q && !sel_reg_now
                   && (port.addr[0] != addr_q[0]);
  wire rd_adv  = oe_rise || a0_toggle;

  // The count saturates at the size; an overrunning host sees zeros
  // instead of wrapping back into words it has already taken
  wire room = xfer_count < xfer_size;
  wire advance = (rd_adv || wr_buf) && room;
  wire [DATA_W-1:0] ptr_sum = xfer_start + xfer_count;
  wire [PTR_W-1:0]  ptr = ptr_sum[PTR_W-1:0];
  // Basic mode folds the selector onto the first four buffers
  wire [BUF_SEL_W-1:0] buf_eff =
    all_buf ? buf_sel
            : {3'h0, buf_sel[BUF_BASIC_W-1:0]};
  wire [MEM_AW-1:0] mem_idx = {buf_eff, ptr};
  wire [DATA_W-1:0] lane_din =
    bus16 ? din_q : {8'h00, din_q[BYTE_W-1:0]};

  always_ff @(posedge core_clk) begin
    if (wr_buf && room) begin
      buf_mem[mem_idx] <= lane_din;
    end
  end

  // Unmapped and read-only indices match nothing, so such writes drop
  wire wr_ctrl  = wr_reg && (wr_idx == REG_CTRL);
  wire wr_start = wr_reg && (wr_idx == REG_XFER_START);
  wire wr_size  = wr_reg && (wr_idx == REG_XFER_SIZE);
  wire wr_bsel  = wr_reg && (wr_idx == REG_BUF_SEL);
  wire wr_waddr = wr_reg && (wr_idx == REG_WAVE_ADDR);
  wire wr_wlo   = wr_reg && (wr_idx == REG_WAVE_LO);
  wire wave_wr  = wr_reg && (wr_idx == REG_WAVE_HI);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl      <= CTRL_RESET;
      xfer_size <= ZERO_WORD;
      buf_sel   <= 5'h00;
      wave_lo   <= ZERO_WORD;
    end else begin
      if (wr_ctrl) ctrl <= din_q;
      if (wr_size) xfer_size <= din_q;
      if (wr_bsel) buf_sel <= din_q[BUF_SEL_W-1:0];
      if (wr_wlo) wave_lo <= din_q;
    end
  end

  // Loading a new start restarts the transfer count
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      xfer_start <= ZERO_WORD;
      xfer_count <= ZERO_WORD;
    end else if (wr_start) begin
      xfer_start <= din_q;
      xfer_count <= ZERO_WORD;
    end else if (advance) begin
      xfer_count <= xfer_count + 16'h0001;
    end
  end

  // Waveform address steps after each committed word for fast loading
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wave_addr <= 11'h000;
    end else if (wr_waddr) begin
      wave_addr <= din_q[WAVE_AW-1:0];
    end else if (wave_wr) begin
      wave_addr <= wave_addr + 11'h001;
    end
  end

  // Reads decode the live address so the first driven cycle is valid
  wire [DATA_W-1:0] reg_rdata =
    (rd_idx == REG_CTRL)       ? ctrl :
    (rd_idx == REG_XFER_START) ? xfer_start :
    (rd_idx == REG_XFER_SIZE)  ? xfer_size :
    (rd_idx == REG_XFER_COUNT) ? xfer_count :
    (rd_idx == REG_BUF_SEL)    ? {11'h000, buf_sel} :
    (rd_idx == REG_WAVE_ADDR)  ? {5'h00, wave_addr} :
    (rd_idx == REG_WAVE_LO)    ? wave_lo :
    (rd_idx == REG_ENG_STATE)  ? {8'h00, eng_state} :
                                 ZERO_WORD;
  wire [DATA_W-1:0] buf_word = buf_mem[mem_idx];
  wire [DATA_W-1:0] buf_rdata =
    !room ? ZERO_WORD :
    (bus16 ? buf_word : {8'h00, buf_word[BYTE_W-1:0]});
  wire [DATA_W-1:0] rd_word =
    sel_reg_now ? reg_rdata : buf_rdata;
  // Drive only for a read strobe; the host owns the bus during writes,
  // and the one-cycle release lag is covered by the host's recovery
  wire rd_drive = !port.ce_n && !port.oe_n && port.we_n;

  // Data is refetched every cycle, so an advance shows the next word
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port.d_dev      <= ZERO_WORD;
      port.d_dev_oe_n <= 1'b1;
    end else begin
      port.d_dev      <= rd_word;
      port.d_dev_oe_n <= !rd_drive;
    end
  end

  // Slave mode steps the engine only while the host holds the port
  wire eng_step = ctrl[CTRL_RUN_BIT]
                  && (ctrl[CTRL_MASTER_BIT] || !port.ce_n);

  hpse_wave_engine u_engine (
    .core_clk (core_clk),
    .rst      (rst),
    .step     (eng_step),
    .wr_en    (wave_wr),
    .wr_addr  (wave_addr),
    .wr_data  ({din_q, wave_lo}),
    .ctl_in   (ctl_in),
    .ctl_out  (ctl_out),
    .ctl_oe_n (ctl_oe_n),
    .int_n    (eng_int_n),
    .state    (eng_state)
  );

  assign port.int_n = eng_int_n;
endmodule // hpse_device

// ---- rtl/hpse_host.sv ----
// Host end of the port: issues SRAM-style single accesses
`timescale 1ns/1ps
module hpse_host
  import hpse_pkg::*;
(
  input  wire logic                 core_clk,  // System clock
  input  wire logic                 rst,       // Async reset, high
  hpse_if.host                      port,      // SRAM-style pins
  input  wire logic                 cmd_valid, // Access request
  input  wire logic                 cmd_write, // One writes, zero reads
  input  wire logic                 cmd_high,  // High address line
  input  wire logic [REG_IDX_W-1:0] cmd_index, // Low address bits
  input  wire logic [DATA_W-1:0]    cmd_wdata, // Write data
  output logic                      cmd_ready, // Ready for a request
  output logic                      rsp_valid, // Access finished
  output logic      [DATA_W-1:0]    rsp_rdata, // Read data
  output logic                      irq        // Interrupt seen, high
);
  hpse_host_state_type      st;
  logic [STROBE_CNT_W-1:0]  cnt;
  logic                     is_write;

  localparam logic [STROBE_CNT_W-1:0] STROBE_LAST =
    STROBE_CNT_W'(MIN_ACCESS_CYC - 1);

  wire take = (st == HPSE_IDLE) && cmd_valid;
  wire strobe_end = (st == HPSE_STROBE) && (cnt == STROBE_LAST);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= HPSE_IDLE;
      cnt <= 3'h0;
      is_write <= 1'b0;
    end else begin
      case (st)
        HPSE_IDLE: begin
          cnt <= 3'h0;
          if (cmd_valid) begin
            is_write <= cmd_write;
            st <= HPSE_STROBE;
          end
        end
        HPSE_STROBE: begin
          cnt <= cnt + 3'h1;
          // Strobe spans the least access cycle
          if (strobe_end) st <= HPSE_RECOVER;
        end
        HPSE_RECOVER: st <= HPSE_IDLE;
        default: st <= HPSE_IDLE;
      endcase
    end
  end

  // The region bit rides its own line so bursts never flip it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port.addr <= 8'h00;
      port.d_host <= ZERO_WORD;
    end else if (take) begin
      port.addr <= {cmd_high, cmd_index};
      port.d_host <= cmd_wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port.ce_n <= 1'b1;
      port.oe_n <= 1'b1;
      port.we_n <= 1'b1;
      port.d_host_oe_n <= 1'b1;
    end else if (take) begin
      port.ce_n <= 1'b0;
      port.oe_n <= cmd_write;
      port.we_n <= !cmd_write;
      port.d_host_oe_n <= !cmd_write;
    end else if (strobe_end) begin
      port.ce_n <= 1'b1;
      port.oe_n <= 1'b1;
      port.we_n <= 1'b1;
    end else if (st == HPSE_RECOVER) begin
      port.d_host_oe_n <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_rdata <= ZERO_WORD;
      irq <= 1'b0;
    end else begin
      cmd_ready <= (st == HPSE_RECOVER)
                   || ((st == HPSE_IDLE) && !cmd_valid);
      rsp_valid <= strobe_end;
      if (strobe_end && !is_write) rsp_rdata <= port.d;
      irq <= !port.int_n;
    end
  end
endmodule // hpse_host

// ---- test/hpse_checker.sv ----
// Timing checks on the pins shared by the host and device ends
`timescale 1ns/1ps
module hpse_checker
  import hpse_pkg::*;
(
  input wire logic              core_clk,    // System clock
  input wire logic              rst,         // Async reset, high
  input wire logic              ce_n,        // Chip enable
  input wire logic              oe_n,        // Output enable
  input wire logic              we_n,        // Write enable
  input wire logic [ADDR_W-1:0] addr,        // Address
  input wire logic              d_host_oe_n, // Host drives data
  input wire logic [DATA_W-1:0] d_dev,       // Device data
  input wire logic              d_dev_oe_n   // Device drives data
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_dev_answers: assert property (
    (!ce_n && !oe_n && we_n) |=> !d_dev_oe_n)
    else $error("device did not drive during a read");
  chk_dev_quiet: assert property (
    !d_dev_oe_n |-> (!$past(ce_n) && !$past(oe_n)))
    else $error("device drove the bus outside a read");
  chk_no_clash: assert property (!(!d_dev_oe_n && !d_host_oe_n))
    else $error("both ends drive the data bus");
  chk_strobe_width: assert property (
    $fell(ce_n) |-> !ce_n [*4] ##1 ce_n)
    else $error("strobe width is not four cycles");
  chk_access_gap: assert property (
    $fell(ce_n) |=> (!$fell(ce_n)) [*5])
    else $error("accesses start too close together");
  chk_addr_steady: assert property (
    (!ce_n && !$past(ce_n)) |-> $stable(addr))
    else $error("address moved inside an access");
  chk_write_hold: assert property (
    $rose(we_n) |-> (!d_host_oe_n && ce_n))
    else $error("host dropped data as the write ended");
  chk_one_strobe: assert property (!(!oe_n && !we_n))
    else $error("read and write strobes both low");
  chk_idle_strobes: assert property (ce_n |-> (oe_n && we_n))
    else $error("strobe low without chip enable");
  chk_reg_data: assert property (
    (addr[REG_SEL_BIT] && !d_dev_oe_n && !$past(d_dev_oe_n))
      |-> $stable(d_dev))
    else $error("register read data changed mid access");
endmodule // hpse_checker

// ---- test/host_port_sram_fifo_engine_test.sv ----
// Bench driving the host end against the device end of the port
`timescale 1ns/1ps
module host_port_sram_fifo_engine_test;
  import hpse_pkg::*;
  logic                 core_clk    = 1'b0;
  logic                 rst         = 1'b1;
  logic                 cmd_valid   = 1'b0;
  logic                 cmd_write   = 1'b0;
  logic                 cmd_high    = 1'b0;
  logic [REG_IDX_W-1:0] cmd_index   = '0;
  logic [DATA_W-1:0]    cmd_wdata   = '0;
  logic [CTL_PINS-1:0]  ctl_in      = '0;
  logic                 cmd_ready;
  logic                 rsp_valid;
  logic [DATA_W-1:0]    rsp_rdata;
  logic                 irq;
  logic [CTL_PINS-1:0]  ctl_out;
  logic [CTL_PINS-1:0]  ctl_oe_n;
  logic [STATE_W-1:0]   eng_state;
  logic [DATA_W-1:0]    rdq [4];
  int                   err_count   = 0;
  int                   check_count = 0;
  int                   cyc         = 0;

  hpse_if hpse_if_inst ();
  hpse_device hpse_device_inst (.core_clk(core_clk), .rst(rst),
    .port(hpse_if_inst), .ctl_in(ctl_in), .ctl_out(ctl_out),
    .ctl_oe_n(ctl_oe_n), .eng_state(eng_state));
  hpse_host hpse_host_inst (.core_clk(core_clk), .rst(rst),
    .port(hpse_if_inst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_high(cmd_high), .cmd_index(cmd_index), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .irq(irq));
  hpse_checker hpse_checker_inst (.core_clk(core_clk), .rst(rst),
    .ce_n(hpse_if_inst.ce_n), .oe_n(hpse_if_inst.oe_n),
    .we_n(hpse_if_inst.we_n), .addr(hpse_if_inst.addr),
    .d_host_oe_n(hpse_if_inst.d_host_oe_n), .d_dev(hpse_if_inst.d_dev),
    .d_dev_oe_n(hpse_if_inst.d_dev_oe_n));

  always #5 core_clk = ~core_clk;

  task automatic conclude();
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Far above the few hundred cycles the scenarios need
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      $display("MISMATCH %0t run did not finish", $time);
      conclude();
    end
  end

  task automatic chk(input logic [DATA_W-1:0] got,
                     input logic [DATA_W-1:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Holds the request for n takes; cmd_ready low marks each take
  task automatic xfer(input logic w, input logic h,
                      input logic [REG_IDX_W-1:0] idx,
                      input logic [DATA_W-1:0] wd, input int n);
    int k;
    int t;
    t = 0;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_high  <= h;
    cmd_index <= idx;
    cmd_wdata <= wd;
    for (k = 0; k < n; k++) begin
      do begin
        @(negedge core_clk);
        t++;
      end while (cmd_ready !== 1'b0 && t < 200);
      if (k == n - 1) begin
        @(posedge core_clk);
        cmd_valid <= 1'b0;
      end
      while (rsp_valid !== 1'b1 && t < 200) begin
        @(negedge core_clk);
        t++;
      end
      rdq[k] = rsp_rdata;
    end
    if (t >= 200) begin
      err_count++;
      $display("MISMATCH %0t access never finished", $time);
    end
  endtask

  task automatic wreg(input logic [REG_IDX_W-1:0] idx,
                      input logic [DATA_W-1:0] v);
    xfer(1'b1, 1'b1, idx, v, 1);
  endtask

  task automatic rreg(input logic [REG_IDX_W-1:0] idx);
    xfer(1'b0, 1'b1, idx, ZERO_WORD, 1);
  endtask

  task automatic ww(input logic [DATA_W-1:0] a, input logic [31:0] w0,
                    input logic [31:0] w1);
    wreg(REG_WAVE_ADDR, a);
    wreg(REG_WAVE_LO, w0[15:0]);
    wreg(REG_WAVE_HI, w0[31:16]);
    wreg(REG_WAVE_LO, w1[15:0]);
    wreg(REG_WAVE_HI, w1[31:16]);
  endtask

  task automatic t_regs();
    rreg(REG_CTRL);
    chk(rdq[0], CTRL_RESET, "ctrl reset");
    wreg(REG_XFER_SIZE, 16'h0005);
    rreg(REG_XFER_SIZE);
    chk(rdq[0], 16'h0005, "size readback");
    wreg(7'h7F, 16'h1234);
    rreg(7'h7F);
    chk(rdq[0], ZERO_WORD, "unmapped index");
    wreg(REG_XFER_COUNT, 16'h0009);
    rreg(REG_XFER_COUNT);
    chk(rdq[0], ZERO_WORD, "count is read only");
  endtask

  task automatic t_buf();
    int i;
    wreg(REG_BUF_SEL, 16'h0001);
    wreg(REG_XFER_START, 16'h0002);
    wreg(REG_XFER_SIZE, 16'h0003);
    for (i = 0; i < 4; i++)
      xfer(1'b1, 1'b0, 7'h00, 16'h1100 + 16'(i), 1);
    rreg(REG_XFER_COUNT);
    chk(rdq[0], 16'h0003, "count stops at size");
    wreg(REG_XFER_START, 16'h0002);
    xfer(1'b0, 1'b0, 7'h00, ZERO_WORD, 4);
    for (i = 0; i < 3; i++)
      chk(rdq[i], 16'h1100 + 16'(i), "burst word");
    chk(rdq[3], ZERO_WORD, "read past size");
    // Basic mode sees only the low two select bits
    wreg(REG_BUF_SEL, 16'h0005);
    wreg(REG_XFER_START, 16'h0002);
    xfer(1'b0, 1'b0, 7'h00, ZERO_WORD, 1);
    chk(rdq[0], 16'h1100, "buffer alias");
    wreg(REG_CTRL, 16'h000C);
    wreg(REG_XFER_START, 16'h0002);
    xfer(1'b1, 1'b0, 7'h00, 16'hBEEF, 1);
    wreg(REG_XFER_START, 16'h0002);
    xfer(1'b0, 1'b0, 7'h00, ZERO_WORD, 1);
    chk(rdq[0], 16'hBEEF, "wide buffer");
    wreg(REG_BUF_SEL, 16'h0001);
    wreg(REG_XFER_START, 16'h0002);
    xfer(1'b0, 1'b0, 7'h00, ZERO_WORD, 1);
    chk(rdq[0], 16'h1100, "buffers kept apart");
  endtask

  task automatic t_byte();
    wreg(REG_CTRL, ZERO_WORD);
    wreg(REG_XFER_START, 16'h0005);
    xfer(1'b1, 1'b0, 7'h00, 16'hA55A, 1);
    wreg(REG_XFER_START, 16'h0005);
    xfer(1'b0, 1'b0, 7'h00, ZERO_WORD, 1);
    chk(rdq[0], 16'h005A, "byte mode");
    wreg(REG_CTRL, CTRL_RESET);
  endtask

  task automatic t_eng();
    int t;
    // State 0 waits on control pin 0; state 2 drives pins and interrupt
    // and falls back to state 0 once pin 0 drops
    ww(16'h0000, 32'h0020_0002, 32'h0000_0000);
    ww(16'h0010, 32'h0000_0002, 32'hFFFF_A5A5);
    // Slave mode steps only while the host holds chip enable low
    @(posedge core_clk);
    ctl_in <= 16'h0001;
    wreg(REG_CTRL, 16'h0005);
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk({8'h00, eng_state}, 16'h0000, "slave idle");
    rreg(REG_CTRL);
    chk(rdq[0], 16'h0005, "slave ctrl");
    chk({8'h00, eng_state}, 16'h0002, "slave step");
    chk({15'h0000, irq}, 16'h0001, "slave interrupt");
    // Pin 0 low sends state 2 home during the next access
    @(posedge core_clk);
    ctl_in <= 16'h0000;
    wreg(REG_CTRL, 16'h0007);
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk({8'h00, eng_state}, 16'h0000, "state held");
    chk(ctl_oe_n, 16'hFFFF, "pins idle");
    chk({15'h0000, irq}, 16'h0000, "no interrupt");
    @(posedge core_clk);
    ctl_in <= 16'h0001;
    t = 0;
    while (irq !== 1'b1 && t < 40) begin
      @(negedge core_clk);
      t++;
    end
    chk({8'h00, eng_state}, 16'h0002, "state moved");
    chk(ctl_out, 16'hA5A5, "pin drive");
    chk(ctl_oe_n, 16'h0000, "pins output");
    chk({15'h0000, irq}, 16'h0001, "interrupt");
    rreg(REG_ENG_STATE);
    chk(rdq[0], 16'h0002, "state register");
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_buf();
    t_byte();
    t_eng();
    conclude();
  end
endmodule // host_port_sram_fifo_engine_test
